// *** src/aps_pin_scan.sv ***
// converter pin configuration, scan list and conversion clock, APB slave
`timescale 1ns/100ps
`default_nettype none
module aps_pin_scan #(
  parameter int unsigned CHAN_N = aps_pkg::APS_CHAN_N,
  parameter int unsigned DIV_W  = aps_pkg::APS_DIV_W
) (
  // clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic                 clkEn,
  // register bus
  input  wire aps_pkg::aps_apb_req_t apbReq,
  output aps_pkg::aps_apb_rsp_t     apbRsp,
  // pin configuration to the pads and analog mux
  output aps_pkg::aps_pin_cfg_t     pinCfg,
  // scan sequencer and conversion clock
  output aps_pkg::aps_scan_t        scan,
  output logic                      convClkTick
);
  import aps_pkg::*;

  logic [APS_REG_W-1:0] pinMode_r;
  logic [APS_REG_W-1:0] scanSel_r;
  logic [DIV_W-1:0]     divider_r;
  logic                 scanEn_r;
  logic [APS_CHAN_W-1:0] chan_r;
  logic                 active_r;
  logic                 step_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [APS_DATA_W-1:0] prdata_r;
  logic [CHAN_N-1:0]    digital_r;
  logic [CHAN_N-1:0]    readEn_r;
  logic [CHAN_N-1:0]    sample_r;
  logic                 tick;
  logic                 tick_r;
  logic                 divRestart;
  logic                 setup;
  logic                 wrDone;
  logic                 mapped;
  logic [APS_REG_W-1:0] wrMasked;
  logic [CHAN_N-1:0]    scanList;
  logic [APS_CHAN_W-1:0] chanNxt;
  logic                 anySel;
  logic [APS_DATA_W-1:0] rdNxt;

  // bus decode
  assign setup  = apbReq.psel && !apbReq.penable;
  assign wrDone = apbReq.psel && apbReq.penable && pready_r && apbReq.pwrite;
  assign mapped = (apbReq.paddr == APS_OFS_PIN_MODE) ||
                  (apbReq.paddr == APS_OFS_SCAN_SEL) ||
                  (apbReq.paddr == APS_OFS_CONV_CTRL) ||
                  (apbReq.paddr == APS_OFS_STATUS);
  // upper bits and holes are dropped on write
  assign wrMasked = apbReq.pwdata[APS_REG_W-1:0] & APS_IMPL_MASK;

  // read mux, answered in the access cycle
  always_comb begin
    rdNxt = '0;
    unique case (apbReq.paddr)
      APS_OFS_PIN_MODE:  rdNxt[APS_REG_W-1:0] = pinMode_r & APS_IMPL_MASK;
      APS_OFS_SCAN_SEL:  rdNxt[APS_REG_W-1:0] = scanSel_r & APS_IMPL_MASK;
      APS_OFS_CONV_CTRL: begin
        rdNxt[APS_CTRL_DIV_LSB +: DIV_W] = divider_r;
        rdNxt[APS_CTRL_SCAN_BIT]         = scanEn_r;
      end
      APS_OFS_STATUS: begin
        rdNxt[APS_STAT_CHAN_LSB +: APS_CHAN_W] = chan_r;
        rdNxt[APS_STAT_ACT_BIT]                = active_r;
      end
      default: rdNxt = '0;
    endcase
  end

  // one wait-free access phase: ready rises in the cycle after setup
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else if (clkEn) begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r  <= (setup && !apbReq.pwrite) ? rdNxt : '0;
    end
  end

  // pin configuration register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMode_r <= APS_RST_PIN_MODE;
    end else if (clkEn && wrDone && apbReq.paddr == APS_OFS_PIN_MODE) begin
      pinMode_r <= wrMasked;
    end
  end

  // scan selection register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scanSel_r <= APS_RST_SCAN_SEL;
    end else if (clkEn && wrDone && apbReq.paddr == APS_OFS_SCAN_SEL) begin
      scanSel_r <= wrMasked;
    end
  end

  // conversion control register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      divider_r <= APS_RST_DIVIDER;
      scanEn_r  <= 1'b0;
    end else if (clkEn && wrDone && apbReq.paddr == APS_OFS_CONV_CTRL) begin
      divider_r <= apbReq.pwdata[APS_CTRL_DIV_LSB +: DIV_W];
      scanEn_r  <= apbReq.pwdata[APS_CTRL_SCAN_BIT];
    end
  end

  // a new divider starts a fresh period so no short tick slips out
  assign divRestart = wrDone && apbReq.paddr == APS_OFS_CONV_CTRL;

  aps_conv_clock #(
    .DIV_W (DIV_W)
  ) u_conv_clock (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clkEn    (clkEn),
    .restart  (divRestart),
    .divider  (divider_r),
    .convTick (tick)
  );

  // per-channel pad controls
  genvar gi;
  generate
    for (gi = 0; gi < CHAN_N; gi++) begin : g_pin
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          digital_r[gi] <= 1'b0;
          readEn_r[gi]  <= 1'b0;
          sample_r[gi]  <= 1'b0;
        end else if (clkEn) begin
          digital_r[gi] <= pinMode_r[gi];
          readEn_r[gi]  <= pinMode_r[gi];
          // holes have no pad, so they never sample
          sample_r[gi]  <= !pinMode_r[gi] && APS_IMPL_MASK[gi];
        end
      end
      assign scanList[gi] = scanSel_r[gi];
    end
  endgenerate

  // next selected channel above the current one, else lowest selected
  always_comb begin
    logic found;
    logic [APS_CHAN_W-1:0] lowest;
    found   = 1'b0;
    lowest  = '0;
    anySel  = 1'b0;
    chanNxt = '0;
    for (int i = CHAN_N - 1; i >= 0; i--) begin
      if (scanList[i]) begin
        lowest = APS_CHAN_W'(i);
        anySel = 1'b1;
        if (APS_CHAN_W'(i) > chan_r) begin
          chanNxt = APS_CHAN_W'(i);
          found   = 1'b1;
        end
      end
    end
    if (!found) begin
      chanNxt = lowest;
    end
  end

  // scan sequencer, one step per conversion clock tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_r   <= '0;
      active_r <= 1'b0;
      step_r   <= 1'b0;
    end else if (clkEn) begin
      step_r <= 1'b0;
      if (!scanEn_r || !anySel) begin
        active_r <= 1'b0;
      end else if (!active_r) begin
        // first step lands on the next selected channel above chan_r, else the lowest selected
        active_r <= 1'b1;
        chan_r   <= chanNxt;
        if (!scanList[chan_r] || chan_r != chanNxt) begin
          chan_r <= chanNxt;
        end
        step_r   <= 1'b1;
      end else if (tick) begin
        chan_r <= chanNxt;
        step_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_r <= 1'b0;
    end else if (clkEn) begin
      tick_r <= tick;
    end
  end

  // outputs straight from flops
  assign apbRsp.pready        = pready_r;
  assign apbRsp.pslverr       = pslverr_r;
  assign apbRsp.prdata        = prdata_r;
  assign pinCfg.digitalSel    = digital_r;
  assign pinCfg.portReadEn    = readEn_r;
  assign pinCfg.analogSampleEn = sample_r;
  assign scan.active          = active_r;
  assign scan.channel         = chan_r;
  assign scan.stepPulse       = step_r;
  assign convClkTick          = tick_r;

endmodule
`default_nettype wire

// *** pkg/aps_pkg.sv ***
// constants, register map and carrier types of the converter pin/scan block
// Function
// - bit one: pin digital, port read enabled
// - bit zero: pin analog, converter samples it
// - pin bits 12-10, 5-0, reset zero
// - scan bit one: channel joins the scan
// - scan bit zero: channel skipped; reset zero
// - unimplemented bits read zero, writes ignored
// - conversion period equals cycle times divider plus one
// - instruction cycle is two oscillator periods
package aps_pkg;

  localparam int unsigned APS_ADDR_W     = 8;
  localparam int unsigned APS_DATA_W     = 32;
  localparam int unsigned APS_CHAN_N     = 13;
  localparam int unsigned APS_CHAN_W     = 4;
  localparam int unsigned APS_DIV_W      = 8;
  localparam int unsigned APS_REG_W      = 16;

  // byte addresses
  localparam logic [APS_ADDR_W-1:0] APS_OFS_PIN_MODE  = 8'h00;
  localparam logic [APS_ADDR_W-1:0] APS_OFS_SCAN_SEL  = 8'h04;
  localparam logic [APS_ADDR_W-1:0] APS_OFS_CONV_CTRL = 8'h08;
  localparam logic [APS_ADDR_W-1:0] APS_OFS_STATUS    = 8'h0C;

  // implemented bits: 12-10 and 5-0
  localparam logic [APS_REG_W-1:0] APS_IMPL_MASK = 16'h1C3F;

  // reset values
  localparam logic [APS_REG_W-1:0] APS_RST_PIN_MODE = 16'h0000;
  localparam logic [APS_REG_W-1:0] APS_RST_SCAN_SEL = 16'h0000;
  localparam logic [APS_DIV_W-1:0] APS_RST_DIVIDER  = 8'h00;

  // conversion control field positions
  localparam int unsigned APS_CTRL_DIV_LSB  = 0;
  localparam int unsigned APS_CTRL_SCAN_BIT = 8;

  // status field positions
  localparam int unsigned APS_STAT_CHAN_LSB = 0;
  localparam int unsigned APS_STAT_ACT_BIT  = 4;

  // oscillator periods in one instruction cycle
  localparam int unsigned APS_OSC_PER_CYCLE = 2;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APS_ADDR_W-1:0] paddr;
    logic [APS_DATA_W-1:0] pwdata;
  } aps_apb_req_t;

  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [APS_DATA_W-1:0] prdata;
  } aps_apb_rsp_t;

  typedef struct packed {
    logic [APS_CHAN_N-1:0] digitalSel;
    logic [APS_CHAN_N-1:0] portReadEn;
    logic [APS_CHAN_N-1:0] analogSampleEn;
  } aps_pin_cfg_t;

  typedef struct packed {
    logic                  active;
    logic [APS_CHAN_W-1:0] channel;
    logic                  stepPulse;
  } aps_scan_t;

endpackage

// *** src/aps_conv_clock.sv ***
// conversion clock tick generator, period = core cycle * (divider + 1)
`timescale 1ns/100ps
`default_nettype none
module aps_conv_clock #(
  parameter int unsigned DIV_W = aps_pkg::APS_DIV_W
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             clkEn,
  // control
  input  wire logic             restart,
  input  wire logic [DIV_W-1:0] divider,
  // tick
  output logic                  convTick
);
  import aps_pkg::*;

  logic [DIV_W-1:0] count_r;

  // core_clk is the instruction clock, already two oscillator periods
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= '0;
    end else if (clkEn) begin
      if (restart || count_r == divider) begin
        count_r <= '0;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  // one tick per conversion clock period
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      convTick <= 1'b0;
    end else if (clkEn) begin
      convTick <= !restart && (count_r == divider);
    end
  end

endmodule
`default_nettype wire

// *** tb/aps_pin_scan_monitor.sv ***
// assertions on the pin/scan block ports
`timescale 1ns/100ps
`default_nettype none
module aps_pin_scan_monitor (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  arst_n,
  input wire logic                  clkEn,
  // bus and outputs
  input wire aps_pkg::aps_apb_req_t apbReq,
  input wire aps_pkg::aps_apb_rsp_t apbRsp,
  input wire aps_pkg::aps_pin_cfg_t pinCfg,
  input wire aps_pkg::aps_scan_t    scan,
  input wire logic                  convClkTick
);
  import aps_pkg::*;
  logic                 up_r;
  logic [1:0]           vld_r;
  logic [7:0]           gap_r;
  logic [7:0]           div_r;
  logic [APS_REG_W-1:0] sel_r;
  wire logic acc = apbReq.psel && apbReq.penable && apbRsp.pready
    && clkEn && apbReq.pwrite;
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) up_r <= 1'b0;
    else if (clkEn) up_r <= 1'b1;
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) sel_r <= '0;
    else if (acc && apbReq.paddr == APS_OFS_SCAN_SEL)
      sel_r <= apbReq.pwdata[15:0] & APS_IMPL_MASK;
  // first tick after a restart may be a stale one, so skip two
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) begin
      vld_r <= '0;
      gap_r <= '0;
      div_r <= '0;
    end else if (clkEn) begin
      if (acc && apbReq.paddr == APS_OFS_CONV_CTRL) begin
        vld_r <= '0;
        gap_r <= '0;
        div_r <= apbReq.pwdata[7:0];
      end else if (convClkTick) begin
        vld_r <= {vld_r[0], 1'b1};
        gap_r <= '0;
      end else
        gap_r <= gap_r + 8'h01;
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_setup;
    apbReq.psel && !apbReq.penable && clkEn;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> apbRsp.pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (apbRsp.pready && clkEn |=>
    !apbRsp.pready) else $error("ready held too long");
  a_read_follows: assert property (
    pinCfg.portReadEn == pinCfg.digitalSel) else $error("port read wrong");
  a_analog_inverse: assert property (
    up_r |-> pinCfg.analogSampleEn ==
    (~pinCfg.digitalSel & APS_IMPL_MASK[12:0])) else $error("analog wrong");
  a_pin_unimpl_zero: assert property (
    (pinCfg.digitalSel & ~APS_IMPL_MASK[12:0]) == '0)
    else $error("unimplemented pin set");
  a_reg_unimpl_zero: assert property (apbRsp.pready &&
    apbReq.paddr[7:3] == '0 |-> (apbRsp.prdata & ~{16'h0000, APS_IMPL_MASK})
    == '0) else $error("unimplemented bit read one");
  a_tick_period: assert property (
    clkEn && convClkTick && vld_r[1] |-> gap_r == div_r)
    else $error("tick period wrong");
  a_step_selected: assert property (scan.stepPulse |->
    sel_r[scan.channel]) else $error("unselected channel scanned");
endmodule
bind aps_pin_scan aps_pin_scan_monitor u_mon (.core_clk(core_clk),
  .arst_n(arst_n), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp),
  .pinCfg(pinCfg), .scan(scan), .convClkTick(convClkTick));
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the pin/scan block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import aps_pkg::*;
  logic         core_clk;
  logic         arst_n;
  logic         clkEn;
  aps_apb_req_t req;
  aps_apb_rsp_t rsp;
  aps_pin_cfg_t pin;
  aps_scan_t    scan;
  logic [31:0]  rd;
  logic         err;
  int           mismatches, comparisons, seed, pinM, selM, cur, n;
  aps_pin_scan dut (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
    .apbReq(req), .apbRsp(rsp), .pinCfg(pin), .scan(scan), .convClkTick());
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, ex);
    comparisons++;
    if (seen !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bail(input int k);
    if (k >= 40) begin
      mismatches++;
      wrap_up();
    end
  endtask
  // idle edge at the end keeps releases and setups apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 40);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge core_clk);
    bail(n);
  endtask
  function automatic int nxt(input int c);
    for (int k = 1; k <= APS_CHAN_N; k++)
      if (selM[(c + k) % APS_CHAN_N]) return (c + k) % APS_CHAN_N;
    return c;
  endfunction
  initial begin
    seed = 64528;
    mismatches = 0;
    comparisons = 0;
    req = '0;
    clkEn = 1'b1;
    arst_n = 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, APS_OFS_PIN_MODE, '0);
    check("pin reset", rd, '0);
    apb(1'b0, APS_OFS_SCAN_SEL, '0);
    check("scan reset", rd, '0);
    check("analog reset", pin.analogSampleEn, APS_IMPL_MASK);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    apb(1'b0, 8'h10, '0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, '0);
    apb(1'b0, APS_OFS_STATUS, '0);
    check("status reset", rd, '0);
    selM = ($random(seed) & APS_IMPL_MASK) | 16'h0400;
    // holes are written as ones and must not stick
    apb(1'b1, APS_OFS_SCAN_SEL, selM | 32'hFFFF_E3C0);
    apb(1'b0, APS_OFS_SCAN_SEL, '0);
    check("scan readback", rd, selM);
    apb(1'b1, APS_OFS_CONV_CTRL, 32'h0000_0002);
    apb(1'b0, APS_OFS_CONV_CTRL, '0);
    check("divider", rd, 32'h0000_0002);
    apb(1'b1, APS_OFS_CONV_CTRL, 32'h0000_0102);
    cur = 0;
    for (int k = 0; k < 12; k++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (scan.stepPulse !== 1'b1 && n < 40);
      bail(n);
      if (k > 0) check("step gap", n, 2 + 1);
      check("scan active", scan.active, 1'b1);
      cur = nxt(cur);
      check("scan channel", scan.channel, cur);
    end
    clkEn <= 1'b0;
    repeat (6) @(posedge core_clk);
    check("frozen channel", scan.channel, cur);
    clkEn <= 1'b1;
    apb(1'b1, APS_OFS_CONV_CTRL, '0);
    apb(1'b0, APS_OFS_STATUS, '0);
    check("status idle", rd[APS_STAT_ACT_BIT], 1'b0);
    check("scan idle", scan.active, 1'b0);
    for (int k = 0; k < 4; k++) begin
      pinM = k ? $random(seed) : -1;
      apb(1'b1, APS_OFS_PIN_MODE, pinM);
      @(posedge core_clk);
      check("digital", pin.digitalSel, pinM & APS_IMPL_MASK);
      check("port read", pin.portReadEn, pinM & APS_IMPL_MASK);
      check("analog", pin.analogSampleEn, ~pinM & APS_IMPL_MASK);
      apb(1'b0, APS_OFS_PIN_MODE, '0);
      check("pin readback", rd, pinM & APS_IMPL_MASK);
    end
    // a second reset must bring back the power-on values
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, APS_OFS_PIN_MODE, '0);
    check("pin rereset", rd, '0);
    apb(1'b0, APS_OFS_SCAN_SEL, '0);
    check("scan rereset", rd, '0);
    check("analog rereset", pin.analogSampleEn, APS_IMPL_MASK);
    wrap_up();
  end
endmodule
`default_nettype wire
